//--- design/ana_map_pkg.sv
// Types shared by the analog output mapper
package ana_map_pkg;
   // =========================================
   // Output range and evaluation function selections
   typedef enum logic [2:0] {
      RNG_OFF, RNG_0_5V, RNG_0_10V, RNG_0_11V, RNG_4_20MA, RNG_0_20MA, RNG_0_24MA
   } range_t;
   typedef enum logic [2:0] {
      FN_OFF, FN_FIRST_BLOCKED, FN_FIRST_CLEAR, FN_LAST_BLOCKED, FN_LAST_CLEAR,
      FN_TOTAL_BLOCKED, FN_TOTAL_CLEAR
   } func_t;
   typedef enum logic {PH_LOAD, PH_RUN} phase_t;
   // =========================================
   // Settings kept in non-volatile storage
   typedef struct packed {
      range_t rng;
      func_t fn;
      logic [7:0] start_beam;
      logic [7:0] end_beam;
      logic [7:0] filt_depth;
      logic [7:0] smooth;
   } cfg_t;
   // =========================================
   // Bus and side-port carriers
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
   typedef struct packed {
      logic wr;
      logic [4:0] addr;
      logic [31:0] data;
   } panel_req_t;
   typedef struct packed {
      logic valid;
      logic ok;
      cfg_t cfg;
   } nv_load_t;
   typedef struct packed {
      logic wr;
      cfg_t cfg;
   } nv_save_t;
endpackage

//--- design/ana_map_regs.svh
// Register offsets, field positions, reset values and limits of the analog output mapper
`ifndef ANA_MAP_REGS_SVH
`define ANA_MAP_REGS_SVH
// =========================================
// Register byte offsets
`define AM_OFF_CTRL 5'h00
`define AM_OFF_CURVE 5'h04
`define AM_OFF_FILTER 5'h08
`define AM_OFF_STATUS 5'h0c
`define AM_OFF_BEAMS 5'h10
// =========================================
// Field positions
`define AM_CTRL_RANGE_LSB 0
`define AM_CTRL_FUNC_LSB 4
`define AM_CURVE_START_LSB 0
`define AM_CURVE_END_LSB 8
`define AM_FILT_DEPTH_LSB 0
`define AM_FILT_SMOOTH_LSB 16
`define AM_STAT_REJECT_BIT 16
`define AM_STAT_LOADED_BIT 17
// =========================================
// Reset values
`define AM_RST_START 8'h01
`define AM_RST_END 8'h20
`define AM_RST_FILT 8'h01
`define AM_RST_SMOOTH 8'h00
// =========================================
// Limits and scale
`define AM_FILT_MAX 9'h0ff
`define AM_FULL_SCALE 13'h1000
`define AM_CODE_MAX 12'hfff
`endif

//--- design/beam_to_analog_output_mapper.sv
// Beam evaluation to 12-bit analog output code mapper with APB configuration
`timescale 1ns/10ps
`include "ana_map_regs.svh"

module beam_to_analog_output_mapper #(
   parameter int NB = 32
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire ana_map_pkg::apb_req_t apb_req,
   output ana_map_pkg::apb_rsp_t apb_rsp,
   input wire logic [NB-1:0] beam_blocked,
   input wire logic meas_tick,
   input wire ana_map_pkg::panel_req_t panel_req,
   input wire ana_map_pkg::nv_load_t nv_load,
   output ana_map_pkg::nv_save_t nv_save,
   output logic [11:0] dac_code,
   output ana_map_pkg::range_t out_range,
   output logic out_enable
);
   import ana_map_pkg::*;

   // =========================================
   // State
   typedef struct packed {
      // Settings and flags
      phase_t phase;
      cfg_t cfg;
      logic reject;
      // Beam synchroniser and filter
      logic [NB-1:0] sync1;
      logic [NB-1:0] sync2;
      logic [NB-1:0] last;
      logic [NB-1:0] stable;
      logic [7:0] cnt;
      // Curve, output and bus registers
      logic [12:0] step;
      logic [11:0] dac;
      range_t rng_out;
      logic out_en;
      apb_rsp_t rsp;
      nv_save_t nv;
   } st_t;

   st_t q;
   st_t d;

   // =========================================
   // Functions
   // Lowest blocked beam number, zero when none
   // Scans downward so the lowest hit is the one left in place
   function automatic logic [7:0] first_set(input logic [NB-1:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = NB - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 8'(i + 1);
         end
      end
      return r;
   endfunction

   // Highest blocked beam number, zero when none
   // Scans upward so the highest hit is the one left in place
   function automatic logic [7:0] last_set(input logic [NB-1:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < NB; i++) begin
         if (v[i]) begin
            r = 8'(i + 1);
         end
      end
      return r;
   endfunction

   // Number of set beams
   // Eight bits hold any count up to the widest curtain
   function automatic logic [7:0] pop(input logic [NB-1:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < NB; i++) begin
         r = r + 8'(v[i]);
      end
      return r;
   endfunction

   // Address is one of the mapped word offsets
   // Upper address bits must be clear so no alias reaches a register
   function automatic logic mapped(input logic [31:0] a);
      logic r;
      r = 1'b0;
      if (a[31:5] == 27'h000_0000) begin
         unique case (a[4:0])
            `AM_OFF_CTRL, `AM_OFF_CURVE, `AM_OFF_FILTER, `AM_OFF_STATUS, `AM_OFF_BEAMS: r = 1'b1;
            default: r = 1'b0;
         endcase
      end
      return r;
   endfunction

   // Filter write that would exceed the depth limit
   function automatic logic too_deep(input logic [4:0] a, input logic [31:0] w);
      return (a == `AM_OFF_FILTER) && (w[`AM_FILT_DEPTH_LSB +: 9] > `AM_FILT_MAX);
   endfunction

   // Apply one configuration write, shared by the bus and the panel
   // One decode for both sources so both refuse the same entries
   function automatic cfg_t cfg_write(input cfg_t c, input logic [4:0] a, input logic [31:0] w);
      cfg_t r;
      r = c;
      unique case (a)
         `AM_OFF_CTRL: begin
            // Codes past the last selection are dropped, no undefined mode can run
            if (w[`AM_CTRL_RANGE_LSB +: 3] <= RNG_0_24MA) begin
               r.rng = range_t'(w[`AM_CTRL_RANGE_LSB +: 3]);
            end
            if (w[`AM_CTRL_FUNC_LSB +: 3] <= FN_TOTAL_CLEAR) begin
               r.fn = func_t'(w[`AM_CTRL_FUNC_LSB +: 3]);
            end
         end
         `AM_OFF_CURVE: begin
            // Either order is legal, a reversed pair inverts the curve
            r.start_beam = w[`AM_CURVE_START_LSB +: 8];
            r.end_beam = w[`AM_CURVE_END_LSB +: 8];
         end
         `AM_OFF_FILTER: begin
            // Smoothing is taken even when the depth is refused
            if (!too_deep(a, w)) begin
               r.filt_depth = w[`AM_FILT_DEPTH_LSB +: 8];
            end
            r.smooth = w[`AM_FILT_SMOOTH_LSB +: 8];
         end
         default: r = c;
      endcase
      return r;
   endfunction

   // Stored settings with an undefined range or function come back as off
   function automatic cfg_t clean_cfg(input cfg_t c);
      cfg_t r;
      r = c;
      if (c.rng > RNG_0_24MA) begin
         r.rng = RNG_OFF;
      end
      if (c.fn > FN_TOTAL_CLEAR) begin
         r.fn = FN_OFF;
      end
      return r;
   endfunction

   // =========================================
   // Combinational next state
   // Bus and panel decode
   logic setup;
   logic access;
   logic bus_wr;
   logic pan_wr;

   // Curve arithmetic
   logic [7:0] lo;
   logic [7:0] hi;
   logic [8:0] nbeams;
   logic [NB-1:0] eff;
   logic [7:0] pos;
   logic [8:0] k;
   logic [21:0] prod;
   logic [11:0] code;

   // Read data
   logic [31:0] rd;

   always_comb begin
      // Every field holds unless a rule below moves it
      d = q;
      // Bus and panel writes only count once the storage load is done, failed or not
      setup = apb_req.psel && !apb_req.penable;
      access = apb_req.psel && apb_req.penable && q.rsp.pready;
      bus_wr = access && apb_req.pwrite && mapped(apb_req.paddr) && (q.phase == PH_RUN);
      pan_wr = panel_req.wr && (q.phase == PH_RUN);

      // Pin synchroniser for the beam states
      // Only the second stage is read, the first may still be settling
      d.sync1 = beam_blocked;
      d.sync2 = q.sync1;

      // Restore saved settings once after power-up
      // A failed load keeps the defaults but still opens the block
      if (q.phase == PH_LOAD && nv_load.valid) begin
         if (nv_load.ok) begin
            d.cfg = clean_cfg(nv_load.cfg);
         end
         d.phase = PH_RUN;
      end

      // Bus write first, panel after it so a tie goes to the panel
      if (bus_wr) begin
         d.cfg = cfg_write(d.cfg, apb_req.paddr[4:0], apb_req.pwdata);
      end
      if (pan_wr) begin
         d.cfg = cfg_write(d.cfg, panel_req.addr, panel_req.data);
      end

      // Sticky reject flag, a new reject beats the clear
      // Set wins, so a refused entry is never lost to a clear in the same cycle
      if (bus_wr && apb_req.paddr[4:0] == `AM_OFF_STATUS && apb_req.pwdata[`AM_STAT_REJECT_BIT]) begin
         d.reject = 1'b0;
      end
      if ((bus_wr && too_deep(apb_req.paddr[4:0], apb_req.pwdata))
         || (pan_wr && too_deep(panel_req.addr, panel_req.data))) begin
         d.reject = 1'b1;
      end

      // Save every change of the settings made after the load
      // One strobe per change, never a run of identical saves
      d.nv.wr = (q.phase == PH_RUN) && (d.cfg != q.cfg);
      d.nv.cfg = d.cfg;

      // Stability filter over measurement cycles
      // The count saturates so a long quiet spell cannot wrap
      if (meas_tick) begin
         if (q.sync2 == q.last) begin
            d.cnt = (q.cnt == 8'hff) ? q.cnt : q.cnt + 8'h01;
         end else begin
            d.cnt = 8'h00;
         end
         d.last = q.sync2;
         if ({1'b0, d.cnt} + 9'h001 >= {1'b0, q.cfg.filt_depth}) begin
            d.stable = q.sync2;
         end
      end

      // Curve span and step per beam
      // Registering the step keeps the divider off the path to the code
      lo = (q.cfg.end_beam < q.cfg.start_beam) ? q.cfg.end_beam : q.cfg.start_beam;
      hi = (q.cfg.end_beam < q.cfg.start_beam) ? q.cfg.start_beam : q.cfg.end_beam;
      nbeams = {1'b0, hi} - {1'b0, lo} + 9'h001;
      d.step = 13'(`AM_FULL_SCALE / {4'h0, nbeams});

      // Small objects are ignored
      // Too few blocked beams count as no object at all
      eff = (pop(q.stable) < q.cfg.smooth) ? '0 : q.stable;

      // Evaluation function result
      // An unknown function code leaves the position at zero
      unique case (q.cfg.fn)
         FN_FIRST_BLOCKED: pos = first_set(eff);
         FN_FIRST_CLEAR: pos = first_set(~eff);
         FN_LAST_BLOCKED: pos = last_set(eff);
         FN_LAST_CLEAR: pos = last_set(~eff);
         FN_TOTAL_BLOCKED: pos = pop(eff);
         FN_TOTAL_CLEAR: pos = pop(~eff);
         default: pos = 8'h00;
      endcase

      // Beam steps inside the span, clamped at either end
      // Position zero means no beam found and lands below the low beam of the span
      if (pos < lo) begin
         k = 9'h000;
      end else if (pos > hi) begin
         k = nbeams;
      end else begin
         k = {1'b0, pos} - {1'b0, lo} + 9'h001;
      end
      prod = 22'(k) * 22'(q.step);
      code = (prod > 22'(`AM_CODE_MAX)) ? `AM_CODE_MAX : prod[11:0];

      // An inverted curve mirrors the code, the end beam side reads high
      if (q.cfg.end_beam < q.cfg.start_beam) begin
         code = `AM_CODE_MAX - code;
      end

      // Off range, off function or not yet loaded give zero
      if (q.cfg.rng == RNG_OFF || q.cfg.fn == FN_OFF || q.phase == PH_LOAD) begin
         d.dac = 12'h000;
      end else begin
         d.dac = code;
      end

      // Range and enable follow the settings, enable waits for the load
      d.rng_out = q.cfg.rng;
      d.out_en = (q.cfg.rng != RNG_OFF) && (q.phase == PH_RUN);

      // Register read mux
      // Unmapped offsets read zero and are flagged with the answer
      unique case (apb_req.paddr[4:0])
         `AM_OFF_CTRL: rd = {25'h000_0000, q.cfg.fn, 1'b0, q.cfg.rng};
         `AM_OFF_CURVE: rd = {16'h0000, q.cfg.end_beam, q.cfg.start_beam};
         `AM_OFF_FILTER: rd = {8'h00, q.cfg.smooth, 8'h00, q.cfg.filt_depth};
         `AM_OFF_STATUS: rd = {14'h0000, (q.phase == PH_RUN), q.reject, 4'h0, q.dac};
         `AM_OFF_BEAMS: rd = 32'(q.stable);
         default: rd = 32'h0000_0000;
      endcase

      // APB answer one cycle after setup
      // A fixed single access cycle needs no wait-state logic
      d.rsp.pready = setup;
      d.rsp.pslverr = setup && !mapped(apb_req.paddr);
      d.rsp.prdata = (setup && !apb_req.pwrite && mapped(apb_req.paddr)) ? rd : 32'h0000_0000;
   end

   // =========================================
   // State register
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         // Whole state to zero, then the fields with other defaults
         q <= '0;
         q.phase <= PH_LOAD;
         q.cfg.rng <= RNG_OFF;
         q.cfg.fn <= FN_OFF;
         q.cfg.start_beam <= `AM_RST_START;
         q.cfg.end_beam <= `AM_RST_END;
         q.cfg.filt_depth <= `AM_RST_FILT;
         q.cfg.smooth <= `AM_RST_SMOOTH;
         q.rng_out <= RNG_OFF;
      end else begin
         q <= d;
      end
   end

   // =========================================
   // Outputs, all from the state register
   // Nothing combinational reaches a pin
   assign apb_rsp = q.rsp;
   assign nv_save = q.nv;
   assign dac_code = q.dac;
   assign out_range = q.rng_out;
   assign out_enable = q.out_en;
endmodule

//--- dv/ana_map_assertions.sv
// Port level assertions for the analog output mapper
`timescale 1ns/10ps
module ana_map_chk import ana_map_pkg::*; #(parameter int NB = 32) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire ana_map_pkg::apb_req_t apb_req,
   input wire ana_map_pkg::apb_rsp_t apb_rsp,
   input wire logic [NB-1:0] beam_blocked,
   input wire logic meas_tick,
   input wire ana_map_pkg::panel_req_t panel_req,
   input wire ana_map_pkg::nv_load_t nv_load,
   input wire ana_map_pkg::nv_save_t nv_save,
   input wire logic [11:0] dac_code,
   input wire ana_map_pkg::range_t out_range,
   input wire logic out_enable
);
   // =========================================
   // Bus answers
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   property p_setup_ready;
      apb_req.psel && !apb_req.penable |=> apb_rsp.pready;
   endproperty
   a_setup_ready: assert property (p_setup_ready) else $error("no answer after setup");
   property p_pready_pulse;
      apb_rsp.pready |=> !apb_rsp.pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse) else $error("ready held too long");
   property p_idle_zero;
      !apb_rsp.pready |-> apb_rsp.prdata == 32'h0000_0000 && !apb_rsp.pslverr;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("read data outside access");
   property p_unmapped;
      apb_req.psel && !apb_req.penable && apb_req.paddr[31:5] != 0 |=> apb_rsp.pslverr && apb_rsp.prdata == 0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_status_dac;
      apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 32'h0000_000c |-> apb_rsp.prdata[11:0] == $past(dac_code);
   endproperty
   a_status_dac: assert property (p_status_dac) else $error("status code differs from output");
   // =========================================
   // Output and storage
   property p_enable_range;
      out_enable |-> out_range != RNG_OFF;
   endproperty
   a_enable_range: assert property (p_enable_range) else $error("output on with range off");
   property p_off_zero;
      (out_range == RNG_OFF) [*4] |-> dac_code == 12'h000;
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("code not zero with range off");
   property p_save_pulse;
      nv_save.wr |=> !nv_save.wr || nv_save.cfg != $past(nv_save.cfg);
   endproperty
   a_save_pulse: assert property (p_save_pulse) else $error("save strobe held");
   c_err: cover property (apb_rsp.pslverr);
   c_save: cover property (nv_save.wr);
   c_full: cover property (dac_code == 12'hfff && out_enable);
endmodule

bind beam_to_analog_output_mapper ana_map_chk #(.NB(NB)) chk_u (.core_clk(core_clk), .arst_n(arst_n),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .beam_blocked(beam_blocked), .meas_tick(meas_tick), .panel_req(panel_req),
   .nv_load(nv_load), .nv_save(nv_save), .dac_code(dac_code), .out_range(out_range), .out_enable(out_enable));

//--- dv/beam_to_analog_output_mapper_tb_top.sv
// Testbench for the analog output mapper
`timescale 1ns/10ps
module beam_to_analog_output_mapper_tb_top;
   import ana_map_pkg::*;
   logic core_clk = 0, arst_n = 0, meas_tick = 0, out_enable, plc_valid, err;
   apb_req_t apb_req = '0;
   apb_rsp_t apb_rsp;
   panel_req_t panel_req = '0;
   nv_load_t nv_load = '0;
   nv_save_t nv_save;
   cfg_t saved = '0;
   range_t out_range;
   logic [31:0] beam_blocked = '0, rd;
   logic [11:0] dac_code, plc_code;
   int n_fail = 0, cmp_count = 0;
   logic [7:0] t_st [8] = '{1, 1, 1, 32, 32, 5, 5, 5};
   logic [7:0] t_en [8] = '{32, 32, 32, 1, 1, 8, 8, 8};
   logic [31:0] t_bm [8] = '{0, '1, 32'h8000_0000, 32'h0000_8000, 0, 32'h0000_0020, 32'h0008_0000, 32'h0000_0002};
   logic [11:0] t_ex [8] = '{0, 4095, 4095, 2047, 4095, 2048, 4095, 0};
   logic [11:0] f_ex [7] = '{0, 512, 128, 1152, 4095, 768, 3328};

   beam_to_analog_output_mapper #(.NB(32)) dut_u (.core_clk(core_clk), .arst_n(arst_n), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .beam_blocked(beam_blocked), .meas_tick(meas_tick), .panel_req(panel_req),
      .nv_load(nv_load), .nv_save(nv_save), .dac_code(dac_code), .out_range(out_range), .out_enable(out_enable));
   plc_model #(.SETTLE(8)) plc_u (.core_clk(core_clk), .arst_n(arst_n), .dac_code(dac_code),
      .out_enable(out_enable), .plc_code(plc_code), .plc_valid(plc_valid));

   // =========================================
   // Clock, watchdog and save monitor
   initial forever #12.5 core_clk = ~core_clk;
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      end_sim;
   end
   always @(posedge core_clk) if (nv_save.wr === 1'b1) saved <= nv_save.cfg;

   // =========================================
   // Shared tasks
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer, held until ready is sampled high
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n = 0;
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         n_fail++;
         end_sim;
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      @(posedge core_clk);
   endtask
   task automatic set_cfg(input logic [2:0] r, input logic [2:0] f, input logic [7:0] s, input logic [7:0] e);
      apb(1'b1, 32'h0000_0000, {25'h0, f, 1'b0, r});
      apb(1'b1, 32'h0000_0004, {16'h0, e, s});
   endtask
   // Beam pattern change followed by measurement ticks and pipeline settling
   task automatic beams(input logic [31:0] b, input int ticks);
      beam_blocked <= b;
      repeat (3) @(posedge core_clk);
      repeat (ticks) begin
         meas_tick <= 1'b1;
         @(posedge core_clk);
         meas_tick <= 1'b0;
         @(posedge core_clk);
      end
      repeat (3) @(posedge core_clk);
   endtask

   // =========================================
   // Main sequence
   initial begin
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      apb(1'b0, 32'h0000_0004, '0);
      chk("curve default", rd, 32'h0000_2001);
      apb(1'b0, 32'h0000_0040, '0);
      chk("unmapped error", {31'h0, err}, 32'h0000_0001);
      nv_load <= '{valid: 1'b1, ok: 1'b0, cfg: '0};
      @(posedge core_clk);
      nv_load <= '0;
      @(posedge core_clk);
      apb(1'b0, 32'h0000_000c, '0);
      chk("loaded", {31'h0, rd[17]}, 32'h0000_0001);
      $display("test defaults done");
      for (int f = 0; f < 7; f++) begin
         set_cfg(3'h4, f[2:0], 8'h01, 8'h20);
         beams(32'h0000_01f8, 1);
         chk("func code", {20'h0, dac_code}, {20'h0, f_ex[f]});
      end
      $display("test functions done");
      for (int i = 0; i < 8; i++) begin
         set_cfg(3'h4, 3'h3, t_st[i], t_en[i]);
         beams(t_bm[i], 1);
         chk("curve code", {20'h0, dac_code}, {20'h0, t_ex[i]});
      end
      repeat (12) @(posedge core_clk);
      chk("plc value", {19'h0, plc_valid, plc_code}, 32'h0000_1000);
      $display("test curves done");
      for (int r = 0; r < 7; r++) begin
         set_cfg(r[2:0], 3'h3, 8'h01, 8'h20);
         beams('1, 1);
         chk("range", {28'h0, out_enable, out_range}, {28'h0, r != 0, r[2:0]});
         chk("range code", {20'h0, dac_code}, (r == 0) ? 32'h0 : 32'h0000_0fff);
      end
      apb(1'b1, 32'h0000_0000, 32'h0000_0077);
      apb(1'b0, 32'h0000_0000, '0);
      chk("ctrl illegal", rd, 32'h0000_0036);
      $display("test ranges done");
      apb(1'b1, 32'h0000_0008, 32'h0002_0100);
      apb(1'b0, 32'h0000_0008, '0);
      chk("filter reject", rd, 32'h0002_0001);
      apb(1'b0, 32'h0000_000c, '0);
      chk("reject flag", {31'h0, rd[16]}, 32'h0000_0001);
      apb(1'b1, 32'h0000_000c, 32'h0001_0000);
      apb(1'b0, 32'h0000_000c, '0);
      chk("reject clear", {31'h0, rd[16]}, 32'h0);
      beams(32'h0000_8000, 1);
      chk("smooth one", {20'h0, dac_code}, 32'h0);
      beams(32'h0001_8000, 1);
      chk("smooth two", {20'h0, dac_code}, 32'h0000_0880);
      apb(1'b0, 32'h0000_0010, '0);
      chk("stable beams", rd, 32'h0001_8000);
      apb(1'b1, 32'h0000_0008, 32'h0000_0004);
      beams(32'h0, 1);
      chk("filter hold", {20'h0, dac_code}, 32'h0000_0880);
      beams(32'h0, 4);
      chk("filter pass", {20'h0, dac_code}, 32'h0);
      chk("saved cfg", saved[31:0], 32'h0120_0400);
      $display("test filter done");
      panel_req <= '{wr: 1'b1, addr: 5'h04, data: 32'h0000_0805};
      @(posedge core_clk);
      panel_req <= '0;
      @(posedge core_clk);
      apb(1'b0, 32'h0000_0004, '0);
      chk("panel curve", rd, 32'h0000_0805);
      $display("test panel done");
      // Mid-run reset, then restore from the saved copy
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("reset outputs", {16'h0, out_enable, out_range, dac_code}, 32'h0);
      arst_n <= 1'b1;
      @(posedge core_clk);
      nv_load <= '{valid: 1'b1, ok: 1'b1, cfg: saved};
      @(posedge core_clk);
      nv_load <= '0;
      @(posedge core_clk);
      apb(1'b0, 32'h0000_0000, '0);
      chk("restored ctrl", rd, 32'h0000_0036);
      apb(1'b0, 32'h0000_0004, '0);
      chk("restored curve", rd, 32'h0000_0805);
      apb(1'b1, 32'h0000_0008, 32'h0000_00ff);
      apb(1'b0, 32'h0000_0008, '0);
      chk("depth limit", rd, 32'h0000_00ff);
      apb(1'b0, 32'h0000_000c, '0);
      chk("limit accepted", {31'h0, rd[16]}, 32'h0);
      $display("test restore done");
      end_sim;
   end
endmodule

//--- dv/plc_model.sv
// Controller model that accepts the analog value once it has settled
`timescale 1ns/10ps
module plc_model #(parameter int SETTLE = 8) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [11:0] dac_code,
   input wire logic out_enable,
   output logic [11:0] plc_code,
   output logic plc_valid
);
   logic [11:0] last_q;
   int cnt_q;
   // Restart the settle count on every change, as the output may still slew
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         last_q <= '0;
         cnt_q <= 0;
         plc_code <= '0;
         plc_valid <= 1'b0;
      end else if (dac_code !== last_q) begin
         last_q <= dac_code;
         cnt_q <= 0;
         plc_valid <= 1'b0;
      end else if (cnt_q < SETTLE) begin
         cnt_q <= cnt_q + 1;
      end else begin
         plc_code <= last_q;
         plc_valid <= out_enable;
      end
   end
endmodule
